// File: rcr_defs.svh
`ifndef RCR_DEFS_SVH
`define RCR_DEFS_SVH
`define START_BYTE 8'h7e
`define TYPE_REMOTE_CMD 8'h17
`define OPT_APPLY 8'h02
`define OPT_APPLY_BIT 1
`define SHORT_UNKNOWN 16'hfffe
`define LONG_BCAST 64'h0000_0000_0000_ffff
`define LONG_COORD 64'h0000_0000_0000_0000
`define CSUM_GOOD 8'hff
`define APPLY_CMD_NAME 16'h4143
`define FIXED_BODY_LEN 16'h000f
`define OFS_TYPE 5'h03
`define OFS_TAG 5'h04
`define OFS_LONG_FIRST 5'h05
`define OFS_LONG_LAST 5'h0c
`define OFS_SHORT_HI 5'h0d
`define OFS_SHORT_LO 5'h0e
`define OFS_OPT 5'h0f
`define OFS_NAME_HI 5'h10
`define OFS_NAME_LO 5'h11
`endif

// File: rcr_pkg.sv
package rcr_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_LEN_HI = 6'b00_0010,
    ST_LEN_LO = 6'b00_0100,
    ST_BODY = 6'b00_1000,
    ST_CSUM = 6'b01_0000,
    ST_DONE = 6'b10_0000
  } frame_state_e;
  typedef logic [7:0] byte_t;
endpackage

// File: rcr_link_if.sv
`timescale 1ns/1ps
interface rcr_link_if;
  logic [7:0] data;
  logic valid;
  logic ready;
  modport host_end (output data, output valid, input ready);
  modport module_end (input data, input valid, output ready);
endinterface

// File: rcr_module_parser.sv
`timescale 1ns/1ps
`include "rcr_defs.svh"
module rcr_module_parser #(
  parameter int MAX_PARAM = 8
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Serial link from host
  rcr_link_if.module_end link,
  // Parsed request
  output logic req_valid_o,
  output rcr_pkg::byte_t req_tag_o,
  output logic [63:0] req_long_addr_o,
  output logic [15:0] req_short_addr_o,
  output logic req_to_coord_o,
  output logic req_bcast_o,
  output logic req_short_unknown_o,
  output logic req_apply_o,
  output logic req_resp_wanted_o,
  output logic req_is_read_o,
  output logic [15:0] req_name_o,
  output logic [MAX_PARAM*8-1:0] req_param_o,
  output logic [7:0] req_param_len_o,
  output logic bad_frame_o,
  output logic apply_changes_command_o
);
  import rcr_pkg::*;

  typedef struct packed {
    frame_state_e st;
    logic [15:0] len;
    logic [15:0] cnt;
    logic [7:0] sum;
    logic type_ok;
    logic [7:0] tag;
    logic [63:0] laddr;
    logic [15:0] saddr;
    logic [7:0] opt;
    logic [15:0] name;
    logic [MAX_PARAM*8-1:0] param;
    logic [7:0] plen;
    logic valid;
    logic bad;
    logic pend_apply;
    logic ac_pulse;
    logic to_coord;
    logic bcast;
    logic short_unk;
    logic apply;
    logic resp;
    logic is_read;
  } parse_s;

  parse_s q, d;
  logic [4:0] ofs;

  assign link.ready = 1'b1;
  assign ofs = (q.cnt > 16'd31) ? 5'h1f : 5'(q.cnt + 16'd3);

  always_comb begin
    d = q;
    d.valid = 1'b0;
    d.bad = 1'b0;
    d.ac_pulse = 1'b0;
    if (link.valid) begin
      case (q.st)
        ST_IDLE, ST_DONE: begin
          if (link.data == `START_BYTE) begin
            d.st = ST_LEN_HI;
          end else begin
            d.st = ST_IDLE;
          end
        end
        ST_LEN_HI: begin
          d.len[15:8] = link.data;
          d.st = ST_LEN_LO;
        end
        ST_LEN_LO: begin
          d.len[7:0] = link.data;
          d.cnt = 16'h0000;
          d.sum = 8'h00;
          d.plen = 8'h00;
          d.param = '0;
          d.st = ({q.len[15:8], link.data} == 16'h0000) ? ST_CSUM : ST_BODY;
        end
        ST_BODY: begin
          d.sum = q.sum + link.data;
          d.cnt = q.cnt + 16'd1;
          if (ofs == `OFS_TYPE) begin
            d.type_ok = (link.data == `TYPE_REMOTE_CMD);
          end else if (ofs == `OFS_TAG) begin
            d.tag = link.data;
          end else if (ofs >= `OFS_LONG_FIRST && ofs <= `OFS_LONG_LAST) begin
            d.laddr = {q.laddr[55:0], link.data};
          end else if (ofs == `OFS_SHORT_HI || ofs == `OFS_SHORT_LO) begin
            d.saddr = {q.saddr[7:0], link.data};
          end else if (ofs == `OFS_OPT) begin
            d.opt = link.data;
          end else if (ofs == `OFS_NAME_HI || ofs == `OFS_NAME_LO) begin
            d.name = {q.name[7:0], link.data};
          end else if (q.plen < 8'(MAX_PARAM)) begin
            // Overlong values keep only the first bytes
            d.param = {q.param[MAX_PARAM*8-9:0], link.data};
            d.plen = q.plen + 8'd1;
          end
          if (q.cnt + 16'd1 == q.len) begin
            d.st = ST_CSUM;
          end
        end
        ST_CSUM: begin
          d.st = ST_DONE;
          if (8'(q.sum + link.data) == `CSUM_GOOD && q.type_ok
              && q.len >= `FIXED_BODY_LEN) begin
            d.valid = 1'b1;
            // Pending changes land on an explicit apply command
            if ((q.opt & `OPT_APPLY) != 8'h00) begin
              d.pend_apply = 1'b0;
            end else if (q.plen != 8'h00) begin
              d.pend_apply = 1'b1;
            end
            if (q.plen == 8'h00 && q.name == `APPLY_CMD_NAME && q.pend_apply) begin
              d.ac_pulse = 1'b1;
              d.pend_apply = 1'b0;
            end
          end else begin
            d.bad = 1'b1;
          end
        end
        default: begin
          d.st = ST_IDLE;
        end
      endcase
    end
    // Decoded from next fields so the flags register in step with them
    d.to_coord = (d.laddr == `LONG_COORD);
    d.bcast = (d.laddr == `LONG_BCAST);
    d.short_unk = (d.saddr == `SHORT_UNKNOWN);
    d.apply = d.opt[`OPT_APPLY_BIT];
    d.resp = (d.tag != 8'h00);
    d.is_read = (d.plen == 8'h00);
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '0;
      q.st <= ST_IDLE;
    end else begin
      q <= d;
    end
  end

  assign req_valid_o = q.valid;
  assign req_tag_o = q.tag;
  assign req_long_addr_o = q.laddr;
  assign req_short_addr_o = q.saddr;
  assign req_to_coord_o = q.to_coord;
  assign req_bcast_o = q.bcast;
  assign req_short_unknown_o = q.short_unk;
  assign req_apply_o = q.apply;
  assign req_resp_wanted_o = q.resp;
  assign req_is_read_o = q.is_read;
  assign req_name_o = q.name;
  assign req_param_o = q.param;
  assign req_param_len_o = q.plen;
  assign bad_frame_o = q.bad;
  assign apply_changes_command_o = q.ac_pulse;
endmodule

// File: rcr_host_framer.sv
`timescale 1ns/1ps
`include "rcr_defs.svh"
module rcr_host_framer #(
  parameter int MAX_PARAM = 8
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Request from user
  input wire logic send_i,
  input wire rcr_pkg::byte_t tag_i,
  input wire logic [63:0] long_addr_i,
  input wire logic [15:0] short_addr_i,
  input wire logic apply_i,
  input wire logic [15:0] name_i,
  input wire logic [MAX_PARAM*8-1:0] param_i,
  input wire logic [7:0] param_len_i,
  output logic busy_o,
  // Serial link to module
  rcr_link_if.host_end link
);
  import rcr_pkg::*;

  localparam int NB = 18 + MAX_PARAM;

  typedef struct packed {
    logic busy;
    logic [7:0] idx;
    logic [7:0] last;
    logic [7:0] sum;
    logic [NB*8-1:0] frame;
    logic [1:0][7:0] buf_data;
    logic [1:0] buf_full;
    logic wr_ptr;
    logic rd_ptr;
  } host_s;

  host_s q, d;
  logic [7:0] plen;
  logic [7:0] cur;
  logic push;

  assign plen = (param_len_i > 8'(MAX_PARAM)) ? 8'(MAX_PARAM) : param_len_i;
  assign cur = q.frame[NB*8-1 -: 8];
  // A full buffer slot stalls frame generation
  assign push = q.busy && !q.buf_full[q.wr_ptr];

  always_comb begin
    logic [15:0] len;
    len = `FIXED_BODY_LEN + {8'h00, plen};
    d = q;
    if (!q.busy && send_i) begin
      d.busy = 1'b1;
      d.idx = 8'h00;
      d.sum = 8'h00;
      d.last = 8'(len) + 8'd3;
      d.frame = '0;
      d.frame[NB*8-1 -: 18*8] = {`START_BYTE, len, `TYPE_REMOTE_CMD, tag_i,
        long_addr_i, short_addr_i,
        apply_i ? `OPT_APPLY : 8'h00,
        name_i};
      for (int i = 0; i < MAX_PARAM; i++) begin
        if (i < int'(plen)) begin
          d.frame[(NB-19-i)*8 +: 8] = param_i[(int'(plen)-1-i)*8 +: 8];
        end
      end
    end else if (push) begin
      d.buf_data[q.wr_ptr] = (q.idx == q.last) ? (`CSUM_GOOD - q.sum) : cur;
      d.buf_full[q.wr_ptr] = 1'b1;
      d.wr_ptr = ~q.wr_ptr;
      if (q.idx >= 8'd3) begin
        d.sum = q.sum + cur;
      end
      d.frame = {q.frame[NB*8-9:0], 8'h00};
      d.idx = q.idx + 8'd1;
      if (q.idx == q.last) begin
        d.busy = 1'b0;
      end
    end
    if (q.buf_full[q.rd_ptr] && link.ready) begin
      d.buf_full[q.rd_ptr] = 1'b0;
      d.rd_ptr = ~q.rd_ptr;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign link.data = q.buf_data[q.rd_ptr];
  assign link.valid = q.buf_full[q.rd_ptr];
  assign busy_o = q.busy;
endmodule

// File: rcr_link_checker.sv
`timescale 1ns/1ps
module rcr_link_checker (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Link signals
  input wire logic [7:0] data,
  input wire logic valid,
  input wire logic ready
);
  logic take;
  logic last;
  logic [7:0] ofs_q;
  logic [7:0] len_q;
  logic [7:0] sum_q;
  assign take = valid & ready;
  // Length high byte is always zero here, so the low byte suffices
  assign last = ofs_q > 8'h02 && ofs_q == len_q + 8'h03;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ofs_q <= 8'h00;
      len_q <= 8'h00;
      sum_q <= 8'h00;
    end else if (take) begin
      ofs_q <= (last || (ofs_q == 8'h00 && data != 8'h7e)) ? 8'h00 : ofs_q + 8'h01;
      len_q <= (ofs_q == 8'h02) ? data : len_q;
      sum_q <= (ofs_q < 8'h03) ? 8'h00 : sum_q + data;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  AST_START: assert property (take && ofs_q == 8'h00 |-> data == 8'h7e) else $error("bad start byte");
  AST_LEN_HI: assert property (take && ofs_q == 8'h01 |-> data == 8'h00) else $error("bad length msb");
  AST_LEN_MIN: assert property (take && ofs_q == 8'h02 |-> data >= 8'h0f) else $error("length too short");
  AST_TYPE: assert property (take && ofs_q == 8'h03 |-> data == 8'h17) else $error("bad frame type");
  AST_OPT: assert property (take && ofs_q == 8'h0f |-> (data & 8'hfd) == 8'h00) else $error("bad option bits");
  AST_CSUM: assert property (take && last |-> sum_q + data == 8'hff) else $error("bad checksum");
  AST_FRAME: assert property (take && ofs_q == 8'h00 |=> ##[0:40] take && last) else $error("frame too long");
  AST_READY: assert property (ready) else $error("module end refused a byte");
  cover property (take && last && len_q == 8'h0f);
  cover property (take && last && len_q > 8'h0f);
  cover property (take && ofs_q == 8'h0f && data[1]);
endmodule

// File: remote_command_request_framer_tb.sv
`timescale 1ns/1ps
module remote_command_request_framer_tb;
  import rcr_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic send_i = 1'b0;
  logic apply_i = 1'b0;
  byte_t tag_i = 8'h00;
  logic [63:0] long_addr_i = 64'h0;
  logic [63:0] param_i = 64'h0;
  logic [15:0] short_addr_i = 16'h0;
  logic [15:0] name_i = 16'h0;
  logic [7:0] param_len_i = 8'h00;
  logic busy, rv, bad, ac, rv2, bad2, saw_ac, r_coord, r_bc, r_unk, r_apl, r_resp, r_rd;
  byte_t r_tag;
  logic [63:0] r_long;
  logic [63:0] r_param;
  logic [15:0] r_short;
  logic [15:0] r_name;
  logic [7:0] r_plen;
  byte_t frm [19] = '{8'h7e, 8'h00, 8'h0f, 8'h17, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                      8'h00, 8'hff, 8'hfe, 8'h00, 8'h42, 8'h48, 8'h61};
  int n_mismatch = 0;
  int num_checks = 0;
  always #2.5 sys_clk_i = ~sys_clk_i;
  rcr_link_if link ();
  // Second link: bench plays a faulty host
  rcr_link_if link2 ();
  rcr_host_framer rcr_host_framer_inst (.sys_clk_i, .rst_b_i, .send_i, .tag_i, .long_addr_i, .short_addr_i,
    .apply_i, .name_i, .param_i, .param_len_i, .busy_o(busy), .link(link));
  rcr_module_parser rcr_module_parser_inst (.sys_clk_i, .rst_b_i, .link(link), .req_valid_o(rv),
    .req_tag_o(r_tag), .req_long_addr_o(r_long), .req_short_addr_o(r_short), .req_to_coord_o(r_coord),
    .req_bcast_o(r_bc), .req_short_unknown_o(r_unk), .req_apply_o(r_apl), .req_resp_wanted_o(r_resp),
    .req_is_read_o(r_rd), .req_name_o(r_name), .req_param_o(r_param), .req_param_len_o(r_plen),
    .bad_frame_o(bad), .apply_changes_command_o(ac));
  rcr_module_parser rcr_module_parser_inst2 (.sys_clk_i, .rst_b_i, .link(link2), .req_valid_o(rv2),
    .req_tag_o(), .req_long_addr_o(), .req_short_addr_o(), .req_to_coord_o(), .req_bcast_o(),
    .req_short_unknown_o(), .req_apply_o(), .req_resp_wanted_o(), .req_is_read_o(), .req_name_o(),
    .req_param_o(), .req_param_len_o(), .bad_frame_o(bad2), .apply_changes_command_o());
  rcr_link_checker rcr_link_checker_inst (.sys_clk_i, .rst_b_i, .data(link.data), .valid(link.valid),
    .ready(link.ready));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic run(input byte_t t, input logic [63:0] la, input logic [15:0] sa, input logic ap,
                     input logic [15:0] nm, input logic [63:0] pv, input logic [7:0] pl);
    int i;
    logic [63:0] m;
    m = ~(64'hffff_ffff_ffff_ffff << (pl * 8));
    @(posedge sys_clk_i);
    {tag_i, long_addr_i, short_addr_i, apply_i, name_i, param_i, param_len_i} <= {t, la, sa, ap, nm, pv, pl};
    send_i <= 1'b1;
    @(posedge sys_clk_i);
    send_i <= 1'b0;
    #1;
    chk(busy, 1'b1);
    saw_ac = 1'b0;
    for (i = 0; i < 60 && rv !== 1'b1; i++) begin
      @(posedge sys_clk_i);
      #1;
      saw_ac |= ac === 1'b1;
    end
    chk(rv, 1'b1);
    chk({r_tag, r_resp}, {t, t != 8'h00});
    chk(r_long, la);
    chk({r_coord, r_bc}, {la == 64'h0, la == 64'h0000_0000_0000_ffff});
    chk({r_short, r_unk}, {sa, sa == 16'hfffe});
    chk(r_apl, ap);
    chk(r_name, nm);
    chk(r_param, pv & m);
    chk(busy, 1'b0);
    chk({r_rd, r_plen}, {pl == 8'h00, pl});
  endtask
  task automatic t_read_coord();
    run(8'h00, 64'h0, 16'hfffe, 1'b0, 16'h4248, 64'h0, 8'h00);
  endtask
  task automatic t_write_bcast();
    run(8'h01, 64'h0000_0000_0000_ffff, 16'hfffe, 1'b1, 16'h4248, 64'h01, 8'h01);
  endtask
  task automatic t_max_param();
    run(8'hff, 64'h0123_4567_89ab_cdef, 16'h1234, 1'b0, 16'h4e49, 64'h8877_6655_4433_2211, 8'h08);
    chk(saw_ac, 1'b0);
  endtask
  task automatic t_apply_cmd(input logic exp);
    run(8'h02, 64'h0, 16'hfffe, 1'b0, 16'h4143, 64'h0, 8'h00);
    chk(saw_ac, exp);
  endtask
  task automatic t_checksum(input byte_t ty, input byte_t cs, input logic good);
    int i;
    logic ok;
    logic nok;
    ok = 1'b0;
    nok = 1'b0;
    for (i = 0; i < 22; i++) begin
      @(posedge sys_clk_i);
      link2.valid <= i < 19;
      // Released bus shows a changing pattern, not the last byte
      link2.data <= i < 19 ? (i == 18 ? cs : (i == 3 ? ty : frm[i])) : ~link2.data;
      #1;
      ok |= rv2 === 1'b1;
      nok |= bad2 === 1'b1;
    end
    chk({ok, nok}, {good, !good});
  endtask
  initial begin
    link2.valid = 1'b0;
    link2.data = 8'h00;
    repeat (2) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    t_read_coord();
    t_write_bcast();
    t_apply_cmd(1'b0);
    t_max_param();
    t_apply_cmd(1'b1);
    t_checksum(8'h17, 8'h62, 1'b0);
    t_checksum(8'h17, 8'h61, 1'b1);
    // Sum is good but the type is wrong
    t_checksum(8'h18, 8'h60, 1'b0);
    tally_and_finish();
  end
  initial begin
    repeat (2000) @(posedge sys_clk_i);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
